// ==== event_status_and_trigger_select.sv ====
// Event status, buffer trigger select and system mode report of the sensor.
// Assumes a register port fed by the serial host engine, with one-cycle read and
// write strobes, and detection functions and buffer on the same clock.
`include "event_status_params.svh"

// Operation
// [RULE1] Trigger select holds four function enables
// [RULE2] Indication sets on rising event, held till read
// [RULE3] Trigger enables reset to zero
// [RULE4] Trigger select is written and read back
// [RULE5] Mode field reports standby, wake or sleep
// [RULE6] Mode register ignores host writes
// [RULE7] Gate error sets on detect, clears on empty
// [RULE8] Gate age counts samples, zero when cleared
// [RULE9] Source bits set on rise, cleared by read
// [RULE10] Interrupt source bit layout, read-only
// [RULE11] Sample ready clears on output data read
// [RULE12] Autosleep event on mode change, cleared reading mode
// [RULE13] Sleep after idle timeout, wake on event
// [RULE14] Buffer event on overflow or watermark match
// [RULE15] Transient event on rising active flag
// [RULE16] Persisting buffer condition re-sets on next sample
// [RULE17] Tap event on rising active flag
// [RULE18] Fall motion event on rising active flag
// [RULE19] Orientation event on new-orientation rise
// [RULE20] Unused bits read zero, writes ignored
// [RULE21] New set beats a coinciding clear
module event_status_and_trigger_select (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       transient_active,
	input  wire logic       orientation_new,
	input  wire logic       tap_active,
	input  wire logic       fall_motion_active,
	input  wire logic       sample_data_ready,
	input  wire event_status_pkg::function_bits_t int_enable,
	input  wire logic       fifo_int_enable,
	input  wire logic       transient_source_read,
	input  wire logic       orientation_status_read,
	input  wire logic       tap_source_read,
	input  wire logic       fall_motion_source_read,
	input  wire logic       output_data_read,
	input  wire logic       fifo_status_read,
	input  wire logic       fifo_overflow,
	input  wire logic [5:0] fifo_count,
	input  wire logic [5:0] fifo_watermark,
	input  wire logic       fifo_push,
	input  wire logic       fifo_empty,
	input  wire logic       gate_error_detect,
	input  wire logic       sample_tick,
	input  wire logic       device_active,
	input  wire logic       autosleep_enable,
	input  wire logic [7:0] sleep_timeout_count,
	input  wire logic       wake_event,
	output logic      [3:0] trigger_enable,
	output logic            buffer_trigger,
	output logic      [1:0] system_mode
);

	event_status_pkg::core_state_t    state;
	event_status_pkg::core_state_t    next_state;
	event_status_pkg::function_bits_t flags;
	event_status_pkg::function_bits_t set_now;
	event_status_pkg::function_bits_t levels;
	event_status_pkg::function_bits_t clears;

	logic [7:0] source_value;
	logic [7:0] mode_value;
	logic [7:0] trigger_value;
	logic [1:0] mode_code;
	logic       fifo_cond;
	logic       fifo_set;
	logic       any_set;
	logic       read_mode_reg;

	// Every function flag shares one cell; only level, enable and clear differ
	assign levels.transient    = transient_active; // [RULE15]
	assign levels.orientation  = orientation_new; // [RULE19]
	assign levels.tap          = tap_active; // [RULE17]
	assign levels.fall_motion  = fall_motion_active; // [RULE18]
	assign levels.sample_ready = sample_data_ready;

	assign clears.transient    = transient_source_read; // [RULE15]
	assign clears.orientation  = orientation_status_read; // [RULE19]
	assign clears.tap          = tap_source_read; // [RULE17]
	assign clears.fall_motion  = fall_motion_source_read; // [RULE18]
	assign clears.sample_ready = output_data_read; // [RULE11]

	edge_sticky_flag u_transient (
		.clk     (clk),
		.rst     (rst),
		.level   (levels.transient),
		.enable  (int_enable.transient),
		.clear   (clears.transient),
		.flag    (flags.transient),
		.set_now (set_now.transient)
	);

	edge_sticky_flag u_orientation (
		.clk     (clk),
		.rst     (rst),
		.level   (levels.orientation),
		.enable  (int_enable.orientation),
		.clear   (clears.orientation),
		.flag    (flags.orientation),
		.set_now (set_now.orientation)
	);

	edge_sticky_flag u_tap (
		.clk     (clk),
		.rst     (rst),
		.level   (levels.tap),
		.enable  (int_enable.tap),
		.clear   (clears.tap),
		.flag    (flags.tap),
		.set_now (set_now.tap)
	);

	edge_sticky_flag u_fall_motion (
		.clk     (clk),
		.rst     (rst),
		.level   (levels.fall_motion),
		.enable  (int_enable.fall_motion),
		.clear   (clears.fall_motion),
		.flag    (flags.fall_motion),
		.set_now (set_now.fall_motion)
	);

	// Status register read at 0x00 is not wired here, so it cannot clear this flag
	edge_sticky_flag u_sample_ready (
		.clk     (clk),
		.rst     (rst),
		.level   (levels.sample_ready),
		.enable  (int_enable.sample_ready),
		.clear   (clears.sample_ready),
		.flag    (flags.sample_ready),
		.set_now (set_now.sample_ready)
	);

	// Buffer condition: overflow, or count exactly at the watermark
	assign fifo_cond = fifo_overflow | (fifo_count == fifo_watermark); // [RULE14]
	// Re-arm on a new sample keeps a persisting condition visible after a clear
	assign fifo_set = fifo_int_enable & ((fifo_cond & ~state.fifo_cond_prev) | (fifo_cond & fifo_push)); // [RULE16]

	// Any new interrupt restarts the idle count toward sleep
	assign any_set = (|set_now) | fifo_set;

	assign read_mode_reg = reg_read & (reg_addr == `SYSTEM_MODE_OFFSET);

	always_comb begin
		mode_code = `MODE_CODE_STANDBY;
		case (state.mode)
			event_status_pkg::mode_standby: mode_code = `MODE_CODE_STANDBY; // [RULE5]
			event_status_pkg::mode_wake:    mode_code = `MODE_CODE_WAKE;
			event_status_pkg::mode_sleep:   mode_code = `MODE_CODE_SLEEP;
			default:                        mode_code = `MODE_CODE_STANDBY;
		endcase
	end

	always_comb begin
		source_value = `READ_ZERO;
		source_value[`AUTOSLEEP_EVENT_BIT]    = state.autosleep_event; // [RULE10]
		source_value[`FIFO_EVENT_BIT]         = state.fifo_event;
		source_value[`TRANSIENT_EVENT_BIT]    = flags.transient;
		source_value[`ORIENTATION_EVENT_BIT]  = flags.orientation;
		source_value[`TAP_EVENT_BIT]          = flags.tap;
		source_value[`FALL_MOTION_EVENT_BIT]  = flags.fall_motion;
		source_value[`UNUSED_SOURCE_BIT]      = 1'b0; // [RULE20]
		source_value[`SAMPLE_READY_EVENT_BIT] = flags.sample_ready;
	end

	always_comb begin
		mode_value = `READ_ZERO;
		mode_value[`GATE_ERROR_BIT]               = state.gate_error;
		mode_value[`GATE_AGE_MSB:`GATE_AGE_LSB]   = state.gate_age;
		mode_value[`MODE_MSB:`MODE_LSB]           = mode_code;
	end

	always_comb begin
		trigger_value = `READ_ZERO; // [RULE20]
		trigger_value[`TRANSIENT_TRIGGER_BIT:`FALL_MOTION_TRIGGER_BIT] = state.trigger_en; // [RULE4]
	end

	always_comb begin
		next_state = state;
		next_state.fifo_cond_prev = fifo_cond;

		// Only bits 5:2 are stored; the rest of a write is dropped
		if (reg_write && reg_addr == `TRIGGER_SELECT_OFFSET) begin // [RULE4]
			next_state.trigger_en = reg_wdata[`TRANSIENT_TRIGGER_BIT:`FALL_MOTION_TRIGGER_BIT]; // [RULE1]
		end
		// Writes to mode and source offsets fall through with no effect

		// Registered read data; unmapped offsets answer zero
		if (reg_read) begin
			if (reg_addr == `TRIGGER_SELECT_OFFSET) begin
				next_state.rdata = trigger_value; // [RULE4]
			end else if (reg_addr == `SYSTEM_MODE_OFFSET) begin
				next_state.rdata = mode_value; // [RULE6]
			end else if (reg_addr == `INTERRUPT_SOURCE_OFFSET) begin
				next_state.rdata = source_value; // [RULE10]
			end else begin
				next_state.rdata = `READ_ZERO;
			end
		end

		// Enabled functions pulse the buffer trigger on their rising event
		next_state.buffer_trigger = |(state.trigger_en &
			{set_now.transient, set_now.orientation, set_now.tap, set_now.fall_motion}); // [RULE1]

		if (fifo_set) begin // [RULE21]
			next_state.fifo_event = 1'b1; // [RULE14]
		end else if (fifo_status_read) begin
			next_state.fifo_event = 1'b0; // [RULE14]
		end

		// Gate error: detection wins over an emptying buffer in the same cycle
		if (gate_error_detect && !state.gate_error) begin // [RULE7]
			next_state.gate_error = 1'b1;
			next_state.gate_age   = `GATE_AGE_RESET;
		end else if (state.gate_error && fifo_empty && !gate_error_detect) begin // [RULE7]
			next_state.gate_error = 1'b0;
			next_state.gate_age   = `GATE_AGE_RESET; // [RULE8]
		end else if (state.gate_error && sample_tick && state.gate_age != `GATE_AGE_MAX) begin
			// Saturates rather than wrapping, so an old error never looks fresh
			next_state.gate_age = state.gate_age + 5'h01; // [RULE8]
		end

		// Idle counter in sample periods; saturates so a long quiet spell stays long
		if (any_set || wake_event) begin
			next_state.idle_count = 9'h000;
		end else if (sample_tick && state.idle_count != `IDLE_COUNT_MAX) begin
			next_state.idle_count = state.idle_count + 9'h001;
		end

		case (state.mode)
			event_status_pkg::mode_standby: begin
				next_state.idle_count = 9'h000;
				if (device_active) begin
					next_state.mode = event_status_pkg::mode_wake;
				end
			end
			event_status_pkg::mode_wake: begin
				if (!device_active) begin
					next_state.mode = event_status_pkg::mode_standby;
				end else if (autosleep_enable && !any_set && !wake_event &&
					state.idle_count > {1'b0, sleep_timeout_count}) begin // [RULE13]
					next_state.mode            = event_status_pkg::mode_sleep;
					next_state.idle_count      = 9'h000;
					next_state.autosleep_event = 1'b1; // [RULE12]
				end
			end
			event_status_pkg::mode_sleep: begin
				if (!device_active) begin
					next_state.mode = event_status_pkg::mode_standby;
				end else if (wake_event || !autosleep_enable) begin // [RULE13]
					next_state.mode            = event_status_pkg::mode_wake;
					next_state.idle_count      = 9'h000;
					next_state.autosleep_event = wake_event; // [RULE12]
				end
			end
			default: begin
				next_state.mode = event_status_pkg::mode_standby;
			end
		endcase

		// Clear when this cycle brings no new mode change, or from standby even if the mode changes
		if (read_mode_reg && next_state.mode == state.mode) begin // [RULE21]
			next_state.autosleep_event = 1'b0; // [RULE12]
		end else if (read_mode_reg && state.mode == event_status_pkg::mode_standby) begin
			next_state.autosleep_event = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state            <= '0;
			state.trigger_en <= `TRIGGER_SELECT_RESET; // [RULE3]
			state.mode       <= event_status_pkg::mode_standby; // [RULE5]
			state.gate_age   <= `GATE_AGE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata      = state.rdata;
	assign trigger_enable = state.trigger_en;
	assign buffer_trigger = state.buffer_trigger;
	assign system_mode    = mode_code;

endmodule

// ==== event_status_params.svh ====
// Register offsets, field positions, reset values and mode codes of the status block.
// Assumes inclusion by bare name from every file that decodes registers.
`ifndef EVENT_STATUS_PARAMS_SVH
`define EVENT_STATUS_PARAMS_SVH

`define TRIGGER_SELECT_OFFSET   8'h0A
`define SYSTEM_MODE_OFFSET      8'h0B
`define INTERRUPT_SOURCE_OFFSET 8'h0C

`define TRANSIENT_TRIGGER_BIT   5
`define ORIENTATION_TRIGGER_BIT 4
`define TAP_TRIGGER_BIT         3
`define FALL_MOTION_TRIGGER_BIT 2
`define TRIGGER_SELECT_RESET    4'h0

`define GATE_ERROR_BIT          7
`define GATE_AGE_MSB            6
`define GATE_AGE_LSB            2
`define GATE_AGE_RESET          5'h00
`define GATE_AGE_MAX            5'h1F
`define MODE_MSB                1
`define MODE_LSB                0
`define MODE_CODE_STANDBY       2'h0
`define MODE_CODE_WAKE          2'h1
`define MODE_CODE_SLEEP         2'h2

`define AUTOSLEEP_EVENT_BIT     7
`define FIFO_EVENT_BIT          6
`define TRANSIENT_EVENT_BIT     5
`define ORIENTATION_EVENT_BIT   4
`define TAP_EVENT_BIT           3
`define FALL_MOTION_EVENT_BIT   2
`define UNUSED_SOURCE_BIT       1
`define SAMPLE_READY_EVENT_BIT  0

`define IDLE_COUNT_MAX          9'h1FF
`define READ_ZERO               8'h00

`endif

// ==== event_status_pkg.sv ====
// Types shared by the status block and its sticky flag cell.
// Assumes nothing beyond a SystemVerilog compiler.
package event_status_pkg;

	typedef enum logic [1:0] {
		mode_standby,
		mode_wake,
		mode_sleep
	} mode_t;

	typedef struct packed {
		logic prev_level;
		logic flag;
	} flag_state_t;

	typedef struct packed {
		logic [3:0] trigger_en;
		mode_t      mode;
		logic       gate_error;
		logic [4:0] gate_age;
		logic       autosleep_event;
		logic       fifo_event;
		logic       fifo_cond_prev;
		logic [8:0] idle_count;
		logic [7:0] rdata;
		logic       buffer_trigger;
	} core_state_t;

	typedef struct packed {
		logic transient;
		logic orientation;
		logic tap;
		logic fall_motion;
		logic sample_ready;
	} function_bits_t;

endpackage

// ==== edge_sticky_flag.sv ====
// Sticky flag cell: sets on a rising enabled level, clears on a read pulse.
// Assumes level, enable and clear come from logic on the same clock.
module edge_sticky_flag (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic level,
	input  wire logic enable,
	input  wire logic clear,
	output logic      flag,
	output logic      set_now
);

	event_status_pkg::flag_state_t state;
	event_status_pkg::flag_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.prev_level = level;
		set_now = level & ~state.prev_level & enable; // [RULE2]
		if (set_now) begin // [RULE21]
			next_state.flag = 1'b1;
		end else if (clear) begin // [RULE9]
			next_state.flag = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign flag = state.flag;

endmodule

// ==== event_status_asserts.sv ====
// Checker of the status block: register port and trigger timing.
// Assumes binding to the block top; one clock, sync reset.
module event_status_asserts (
	input wire logic                            clk,
	input wire logic                            rst,
	input wire logic [7:0]                      reg_addr,
	input wire logic                            reg_write,
	input wire logic                            reg_read,
	input wire logic [7:0]                      reg_wdata,
	input wire logic [7:0]                      reg_rdata,
	input wire logic                            transient_active,
	input wire event_status_pkg::function_bits_t int_enable,
	input wire logic                            device_active,
	input wire logic                            wake_event,
	input wire logic [3:0]                      trigger_enable,
	input wire logic                            buffer_trigger,
	input wire logic [1:0]                      system_mode
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	logic       mapped;
	logic [3:0] wsel;
	assign mapped = reg_addr inside {8'h0A, 8'h0B, 8'h0C};
	assign wsel = reg_wdata[5:2];
	sequence s_sel_wr;
		reg_write && reg_addr == 8'h0A;
	endsequence
	sequence s_trans_rise;
		$rose(transient_active) && int_enable.transient;
	endsequence
	property p_trig_reset;
		$fell(rst) |-> trigger_enable == 4'h0;
	endproperty
	a_trig_reset: assert property (p_trig_reset) else $error("trigger select not clear after reset");
	property p_trig_wr;
		s_sel_wr |=> trigger_enable == $past(wsel);
	endproperty
	a_trig_wr: assert property (p_trig_wr) else $error("trigger select write lost");
	property p_trig_hold;
		!(reg_write && reg_addr == 8'h0A) |=> $stable(trigger_enable);
	endproperty
	a_trig_hold: assert property (p_trig_hold) else $error("trigger select changed without write");
	property p_trig_rd;
		reg_read && reg_addr == 8'h0A |=> reg_rdata == {2'h0, $past(trigger_enable), 2'h0};
	endproperty
	a_trig_rd: assert property (p_trig_rd) else $error("trigger select read wrong");
	property p_mode_rd;
		reg_read && reg_addr == 8'h0B |=> reg_rdata[1:0] == $past(system_mode);
	endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode field read wrong");
	property p_src_gap;
		reg_read && reg_addr == 8'h0C |=> !reg_rdata[1];
	endproperty
	a_src_gap: assert property (p_src_gap) else $error("unused source bit set");
	property p_unmapped;
		reg_read && !mapped |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_standby;
		!device_active |=> system_mode == 2'h0;
	endproperty
	a_standby: assert property (p_standby) else $error("not standby when inactive");
	property p_wake;
		system_mode == 2'h2 && device_active && wake_event |=> system_mode == 2'h1;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from sleep");
	property p_trans_trig;
		s_trans_rise ##0 trigger_enable[3] |=> buffer_trigger;
	endproperty
	a_trans_trig: assert property (p_trans_trig) else $error("enabled transient did not trigger");
	property p_trig_cause;
		buffer_trigger |-> $past(trigger_enable) != 4'h0;
	endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("trigger with no enable");
endmodule

// ==== host_model.sv ====
// Host side of the register port: one-strobe byte writes and reads.
// Assumes read data shows on the edge after the strobe is taken.
module host_model (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic            reg_write,
	output logic            reg_read,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_wdata = 8'h00;
	end
	// Released lines flip, so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		d = reg_rdata;
	endtask
endmodule

// ==== event_status_and_trigger_select_tb_top.sv ====
// Bench of the status block: register reads, flags, buffer event, mode.
// Assumes the host model drives the register port.
`define CHK(a, e) begin \
	n_tests++; \
	if ((a) !== (e)) begin \
		failures++; \
		$display("ERROR %0t got %h exp %h", $time, a, e); \
	end \
end
module event_status_and_trigger_select_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, sdr = 0, fie = 0, ovf = 0, push = 0, empty = 0;
	logic gerr = 0, tick = 0, act = 0, aen = 0, wake = 0;
	logic [3:0] lv = 4'h0;
	logic [5:0] clr = 6'h00;
	logic [5:0] cnt = 6'h00, wm = 6'h20;
	logic [7:0] tmo = 8'hFF;
	logic [7:0] addr, wdata, rdata;
	logic       wr, rd;
	event_status_pkg::function_bits_t ie = 5'h00;
	int failures = 0, n_tests = 0;
	always #5 clk = ~clk;
	host_model u_host (.clk(clk), .reg_addr(addr), .reg_write(wr), .reg_read(rd),
		.reg_wdata(wdata), .reg_rdata(rdata));
	event_status_and_trigger_select u_dut (.clk(clk), .rst(rst), .reg_addr(addr),
		.reg_write(wr), .reg_read(rd), .reg_wdata(wdata), .reg_rdata(rdata),
		.transient_active(lv[3]), .orientation_new(lv[2]), .tap_active(lv[1]),
		.fall_motion_active(lv[0]), .sample_data_ready(sdr), .int_enable(ie),
		.fifo_int_enable(fie), .transient_source_read(clr[3]),
		.orientation_status_read(clr[2]), .tap_source_read(clr[1]),
		.fall_motion_source_read(clr[0]), .output_data_read(clr[5]),
		.fifo_status_read(clr[4]), .fifo_overflow(ovf), .fifo_count(cnt),
		.fifo_watermark(wm), .fifo_push(push), .fifo_empty(empty),
		.gate_error_detect(gerr), .sample_tick(tick), .device_active(act),
		.autosleep_enable(aen), .sleep_timeout_count(tmo), .wake_event(wake),
		.trigger_enable(), .buffer_trigger(), .system_mode());
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		`CHK(d, e)
	endtask
	task automatic pulse_clr(input int i);
		@(posedge clk);
		clr[i] <= 1'b1;
		@(posedge clk);
		clr[i] <= 1'b0;
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
	endtask
	task automatic t_regs;
		rdchk(8'h0A, 8'h00);
		rdchk(8'h0B, 8'h00);
		rdchk(8'h0C, 8'h00);
		u_host.wr(8'h0A, 8'hFF);
		rdchk(8'h0A, 8'h3C);
		u_host.wr(8'h0A, 8'h24);
		rdchk(8'h0A, 8'h24);
		u_host.wr(8'h0B, 8'hFF);
		u_host.wr(8'h0C, 8'hFF);
		rdchk(8'h0B, 8'h00);
		rdchk(8'h0C, 8'h00);
		rdchk(8'h0D, 8'h00);
		u_host.wr(8'h0A, 8'h3C);
		$display("register test done");
	endtask
	task automatic t_funcs;
		@(posedge clk);
		ie <= 5'h1F;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			lv[i] <= 1'b1;
			rdchk(8'h0C, 8'h01 << (i + 2));
			rdchk(8'h0C, 8'h01 << (i + 2));
			lv[i] <= 1'b0;
			pulse_clr(i);
			rdchk(8'h0C, 8'h00);
		end
		// Rise while disabled must not be remembered
		ie.transient <= 1'b0;
		lv[3] <= 1'b1;
		rdchk(8'h0C, 8'h00);
		lv[3] <= 1'b0;
		ie.transient <= 1'b1;
		$display("function flag test done");
	endtask
	task automatic t_ready_fifo;
		@(posedge clk);
		sdr <= 1'b1;
		rdchk(8'h0C, 8'h01);
		rdchk(8'h00, 8'h00);
		rdchk(8'h0C, 8'h01);
		sdr <= 1'b0;
		pulse_clr(5);
		rdchk(8'h0C, 8'h00);
		fie <= 1'b1;
		cnt <= 6'h05;
		wm <= 6'h05;
		rdchk(8'h0C, 8'h40);
		pulse_clr(4);
		rdchk(8'h0C, 8'h00);
		@(posedge clk);
		push <= 1'b1;
		@(posedge clk);
		push <= 1'b0;
		rdchk(8'h0C, 8'h40);
		cnt <= 6'h04;
		pulse_clr(4);
		rdchk(8'h0C, 8'h00);
		// Overflow alone raises the buffer event
		@(posedge clk);
		ovf <= 1'b1;
		rdchk(8'h0C, 8'h40);
		ovf <= 1'b0;
		pulse_clr(4);
		rdchk(8'h0C, 8'h00);
		$display("ready and buffer test done");
	endtask
	task automatic t_gate_mode;
		@(posedge clk);
		gerr <= 1'b1;
		@(posedge clk);
		gerr <= 1'b0;
		ticks(3);
		rdchk(8'h0B, 8'h8C);
		empty <= 1'b1;
		@(posedge clk);
		empty <= 1'b0;
		rdchk(8'h0B, 8'h00);
		act <= 1'b1;
		rdchk(8'h0B, 8'h01);
		aen <= 1'b1;
		tmo <= 8'h02;
		ticks(4);
		rdchk(8'h0C, 8'h80);
		rdchk(8'h0B, 8'h02);
		rdchk(8'h0C, 8'h00);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		rdchk(8'h0C, 8'h80);
		rdchk(8'h0B, 8'h01);
		act <= 1'b0;
		rdchk(8'h0B, 8'h00);
		$display("gate and mode test done");
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_funcs();
		t_ready_fifo();
		t_gate_mode();
		conclude();
	end
	// Whole run is well under a thousand cycles
	initial begin
		#100us;
		failures++;
		conclude();
	end
endmodule
bind event_status_and_trigger_select event_status_asserts u_chk (.clk(clk), .rst(rst),
	.reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .transient_active(transient_active), .int_enable(int_enable),
	.device_active(device_active), .wake_event(wake_event), .trigger_enable(trigger_enable),
	.buffer_trigger(buffer_trigger), .system_mode(system_mode));
